// >>> dcd_ballast_model.sv
`timescale 1ns/100ps
`default_nettype none
module dcd_ballast_model (
   input  wire logic       clk_i,
   input  wire logic       clr_i,
   input  wire logic [7:0] level_i,
   output logic            down_o,
   output logic [7:0]      jump_o
);
   logic [7:0] last_q;
   // ballast follows arc level, notes any fall and largest rise per clock
   always_ff @(posedge clk_i) begin
      last_q <= level_i;
      if (clr_i) begin
         down_o <= 1'b0;
         jump_o <= 8'h00;
      end else begin
         if (level_i < last_q) down_o <= 1'b1;
         if (level_i >= last_q && level_i - last_q > jump_o) jump_o <= level_i - last_q;
      end
   end
endmodule : dcd_ballast_model
`default_nettype wire

// >>> dcd_channel.sv
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dcd_channel #(
   parameter int TICK_CYCLES = dcd_pkg::TICK_CYCLES,
   parameter int HOUR_TICKS  = dcd_pkg::HOUR_TICKS
) (
   input  wire logic                   clk_i,
   input  wire logic                   reset_n_i,
   input  wire logic [dcd_pkg::AW-1:0] avs_address_i,
   input  wire logic                   avs_read_i,
   input  wire logic                   avs_write_i,
   input  wire logic [31:0]            avs_writedata_i,
   input  wire logic [3:0]             avs_byteenable_i,
   output logic [31:0]                 avs_readdata_o,
   output logic                        avs_waitrequest_o,
   output logic [7:0]                  level_o
);
   import dcd_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   dcd_ctrl_t   ctrl_q;
   logic [31:0] limits_q;
   logic [31:0] times_q;
   logic [31:0] dlev_q;
   logic [31:0] dtim_q;
   logic [31:0] rdata_d;
   logic        wr_en;
   dcd_cmd_t    cmd;
   logic        cmd_hit;
   logic        tick;
   logic [7:0]  level;
   logic [7:0]  target;
   logic        busy;
   logic        load;
   dcd_ramp_t   req;
   logic [7:0]  eff_min;
   logic [7:0]  eff_max;
   logic        slave_act;
   logic        slave_act_q;
   logic        slave_evt;
   logic [7:0]  last_set_q;
   logic        down_q;
   logic        down_d;
   dcd_dyn_e    dyn_q;
   dcd_dyn_e    dyn_d;
   logic [7:0]  hold_q;
   logic        hold_ld;
   logic        norm_go;
   logic        dyn_go;
   logic        slave_set;
   logic        burn_q;
   logic        burn_prev_q;
   logic [31:0] burn_cnt_q;
   logic [7:0]  burn_hrs_q;

   // ****************************************
   // helper functions
   // ****************************************
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
   endfunction : merge

   function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp

   // zero means off, any other value is held inside the limits
   function automatic logic [7:0] set_lvl(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
      set_lvl = (v == LVL_OFF) ? LVL_OFF : clamp(v, lo, hi);
   endfunction : set_lvl

   // ****************************************
   // avalon slave
   // ****************************************
   assign wr_en   = avs_write_i & ~avs_waitrequest_o;
   assign cmd_hit = wr_en & (avs_address_i == ADDR_CMD);
   assign cmd     = dcd_cmd_t'(avs_writedata_i);

   // read mux
   always_comb begin
      rdata_d = 32'h0;
      if (avs_address_i == ADDR_CTRL) begin
         rdata_d = ctrl_q;
      end else if (avs_address_i == ADDR_LIMITS) begin
         rdata_d = limits_q;
      end else if (avs_address_i == ADDR_TIMES) begin
         rdata_d = times_q;
      end else if (avs_address_i == ADDR_DYN_LEVEL) begin
         rdata_d = dlev_q;
      end else if (avs_address_i == ADDR_DYN_TIME) begin
         rdata_d = dtim_q;
      end else if (avs_address_i == ADDR_STATUS) begin
         rdata_d = {9'h0, burn_q, busy, dyn_q, target, level};
      end
   end

   // one wait cycle, then answer for one cycle
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0;
      end else if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b0;
         avs_readdata_o    <= avs_read_i ? rdata_d : 32'h0;
      end else begin
         avs_waitrequest_o <= 1'b1;
      end
   end

   // configuration registers
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ctrl_q   <= dcd_ctrl_t'(CTRL_RST);
         limits_q <= LIMITS_RST;
         times_q  <= TIMES_RST;
         dlev_q   <= DYN_LEVEL_RST;
         dtim_q   <= DYN_TIME_RST;
      end else if (wr_en) begin
         if (avs_address_i == ADDR_CTRL) begin
            ctrl_q <= dcd_ctrl_t'(merge(ctrl_q, avs_writedata_i, avs_byteenable_i) & 32'h0000_00ff);
         end else if (avs_address_i == ADDR_LIMITS) begin
            limits_q <= merge(limits_q, avs_writedata_i, avs_byteenable_i) & 32'h00ff_ffff;
         end else if (avs_address_i == ADDR_TIMES) begin
            times_q <= merge(times_q, avs_writedata_i, avs_byteenable_i);
         end else if (avs_address_i == ADDR_DYN_LEVEL) begin
            dlev_q <= merge(dlev_q, avs_writedata_i, avs_byteenable_i) & 32'h00ff_ffff;
         end else if (avs_address_i == ADDR_DYN_TIME) begin
            dtim_q <= merge(dtim_q, avs_writedata_i, avs_byteenable_i) & 32'h00ff_ffff;
         end
      end
   end

   // ****************************************
   // limits and command routing
   // ****************************************
   assign eff_max = limits_q[LIM_MAX_LSB +: 8];
   assign eff_min = (limits_q[LIM_MIN_LSB +: 8] > eff_max) ? eff_max
                                                           : limits_q[LIM_MIN_LSB +: 8];

   assign slave_act = ctrl_q.slave & ~ctrl_q.central;
   assign slave_evt = slave_act & ~slave_act_q;
   assign norm_go   = cmd_hit & (cmd.central | (~ctrl_q.dyn & ~slave_act));
   assign dyn_go    = cmd_hit & ~cmd.central & ctrl_q.dyn & ~slave_act
                      & ((cmd.code == CMD_ON) | (cmd.code == CMD_OFF));
   assign slave_set = cmd_hit & ~cmd.central & slave_act & (cmd.code == CMD_SET);

   // last received non-central set value, kept for slave enable
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         last_set_q  <= LVL_OFF;
         slave_act_q <= 1'b0;
      end else begin
         slave_act_q <= slave_act;
         if (cmd_hit & ~cmd.central & (cmd.code == CMD_SET)) begin
            last_set_q <= cmd.value;
         end
      end
   end

   // ****************************************
   // ramp requests and dynamic sequence
   // ****************************************
   always_comb begin
      load    = 1'b0;
      req     = '{from_start: 1'b0, start: LVL_OFF, target: level, den: 8'h00, rate: 1'b0};
      down_d  = down_q;
      hold_ld = 1'b0;
      dyn_d   = ctrl_q.dyn ? dyn_q : DYN_IDLE;
      if (slave_evt) begin
         load       = 1'b1;
         down_d     = 1'b0;
         req.target = set_lvl(last_set_q, eff_min, eff_max);
      end else if (slave_set) begin
         load       = 1'b1;
         down_d     = 1'b0;
         req.target = set_lvl(cmd.value, eff_min, eff_max);
         req.den    = times_q[TIM_SET_LSB +: 8];
      end else if (norm_go) begin
         case (cmd.code)
            CMD_ON, CMD_OFF: begin
               load       = 1'b1;
               down_d     = 1'b0;
               req.target = (cmd.code == CMD_ON)
                            ? clamp(limits_q[LIM_ON_LSB +: 8], eff_min, eff_max)
                            : LVL_OFF;
               req.rate   = ctrl_q.const_sw;
               req.den    = ctrl_q.const_sw ? times_q[TIM_REL_LSB +: 8] : times_q[TIM_SW_LSB +: 8];
            end
            CMD_SET: begin
               if ((level != LVL_OFF) | ctrl_q.set_on | cmd.central) begin
                  load       = 1'b1;
                  down_d     = 1'b0;
                  req.target = set_lvl(cmd.value, eff_min, eff_max);
                  req.den    = times_q[TIM_SET_LSB +: 8];
               end
            end
            CMD_UP: begin
               if ((level != LVL_OFF) | ctrl_q.perm_on | cmd.central) begin
                  load           = 1'b1;
                  down_d         = 1'b0;
                  req.from_start = (level == LVL_OFF);
                  req.start      = eff_min;
                  req.target     = eff_max;
                  req.rate       = 1'b1;
                  req.den        = times_q[TIM_REL_LSB +: 8];
               end
            end
            CMD_DOWN: begin
               if (level != LVL_OFF) begin
                  load       = 1'b1;
                  down_d     = ctrl_q.perm_off | cmd.central;
                  req.target = (eff_min == LVL_OFF) ? 8'h01 : eff_min;
                  req.rate   = 1'b1;
                  req.den    = times_q[TIM_REL_LSB +: 8];
               end
            end
            CMD_STOP: begin
               load   = 1'b1;
               down_d = 1'b0;
            end
            default: begin
               load = 1'b0;
            end
         endcase
      end else if (down_q & ~busy & (level == target)) begin
         load       = 1'b1;
         down_d     = 1'b0;
         req.target = LVL_OFF;
      end else if (ctrl_q.dyn & ~slave_act) begin
         // levels below are used raw, without limits
         case (dyn_q)
            DYN_IDLE: begin
               if (dyn_go & (cmd.code == CMD_ON)) begin
                  load           = 1'b1;
                  req.from_start = 1'b1;
                  req.start      = dlev_q[DYL_INIT_LSB +: 8];
                  req.target     = dlev_q[DYL_HOLD_LSB +: 8];
                  req.den        = dtim_q[DYT_RISE_LSB +: 8];
                  dyn_d          = DYN_RISE;
               end
            end
            DYN_RISE, DYN_HOLD: begin
               if (dyn_go & (cmd.code == CMD_OFF)) begin
                  load       = 1'b1;
                  req.target = dlev_q[DYL_OFF_LSB +: 8];
                  req.den    = dtim_q[DYT_FALL_LSB +: 8];
                  dyn_d      = DYN_FALL;
               end else if (dyn_q == DYN_RISE) begin
                  if (~busy) begin
                     hold_ld = 1'b1;
                     dyn_d   = DYN_HOLD;
                  end
               end else if (dyn_go) begin
                  hold_ld = 1'b1;
               end else if (hold_q == 8'h00) begin
                  load       = 1'b1;
                  req.target = dlev_q[DYL_OFF_LSB +: 8];
                  req.den    = dtim_q[DYT_FALL_LSB +: 8];
                  dyn_d      = DYN_FALL;
               end
            end
            DYN_FALL, DYN_OFF: begin
               if (dyn_go & (cmd.code == CMD_ON)) begin
                  load       = 1'b1;
                  req.target = dlev_q[DYL_HOLD_LSB +: 8];
                  hold_ld    = 1'b1;
                  dyn_d      = DYN_HOLD;
               end else if ((dyn_q == DYN_FALL) & ~busy) begin
                  dyn_d = DYN_OFF;
               end
            end
            default: begin
               dyn_d = DYN_IDLE;
            end
         endcase
      end
   end

   // dynamic state, hold timer and dim-down flag
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         dyn_q  <= DYN_IDLE;
         hold_q <= 8'h00;
         down_q <= 1'b0;
      end else begin
         dyn_q  <= dyn_d;
         down_q <= down_d;
         if (hold_ld) begin
            hold_q <= dtim_q[DYT_HOLD_LSB +: 8];
         end else if (tick & (dyn_q == DYN_HOLD) & (hold_q != 8'h00)) begin
            hold_q <= hold_q - 8'h01;
         end
      end
   end

   // ****************************************
   // burn-in
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         burn_q      <= 1'b0;
         burn_prev_q <= 1'b0;
         burn_cnt_q  <= 32'h0;
         burn_hrs_q  <= 8'h00;
      end else begin
         burn_prev_q <= ctrl_q.burn_en;
         if (ctrl_q.burn_en & ~burn_prev_q) begin
            burn_q     <= 1'b1;
            burn_cnt_q <= 32'h0;
            burn_hrs_q <= times_q[TIM_BURN_LSB +: 8];
         end else if (~ctrl_q.burn_en | (burn_hrs_q == 8'h00)) begin
            burn_q <= 1'b0;
         end else if (burn_q & tick) begin
            if (burn_cnt_q == 32'(HOUR_TICKS - 1)) begin
               burn_cnt_q <= 32'h0;
               burn_hrs_q <= burn_hrs_q - 8'h01;
            end else begin
               burn_cnt_q <= burn_cnt_q + 32'h1;
            end
         end
      end
   end

   // ****************************************
   // ramp engine and output
   // ****************************************
   dcd_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .tick_o    (tick)
   );

   dcd_ramp u_ramp (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .tick_i    (tick),
      .load_i    (load),
      .req_i     (req),
      .level_o   (level),
      .target_o  (target),
      .busy_o    (busy)
   );

   // burn-in forces lit channels to full
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         level_o <= LVL_OFF;
      end else if (burn_q) begin
         level_o <= (level != LVL_OFF) ? LVL_FULL : LVL_OFF;
      end else begin
         level_o <= level;
      end
   end
endmodule : dcd_channel
`default_nettype wire

// >>> dcd_channel_properties.sv
`timescale 1ns/100ps
`default_nettype none
module dcd_channel_properties (
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   input wire logic [4:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic [7:0]  level_o
);
   import dcd_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // request, and read answer in this cycle
   wire logic rq = avs_read_i | avs_write_i;
   wire logic ra = avs_read_i & ~avs_waitrequest_o;
   // ****************************************
   // bus contract
   // ****************************************
   ans_one_a: assert property (rq && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
   ans_short_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer too long");
   no_spur_a: assert property (!rq |=> avs_waitrequest_o) else $error("answer without request");
   cmd_zero_a: assert property (ra && avs_address_i == ADDR_CMD |-> avs_readdata_o == 32'h0)
      else $error("command word not zero");
   unmap_zero_a: assert property (ra && avs_address_i > ADDR_STATUS |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   ctrl_rsvd_a: assert property (ra && avs_address_i == ADDR_CTRL |-> avs_readdata_o[31:8] == 24'h0)
      else $error("control reserved bits");
   stat_fmt_a: assert property (ra && avs_address_i == ADDR_STATUS
      |-> avs_readdata_o[31:23] == 9'h0 && $onehot(avs_readdata_o[20:16])) else $error("status format");
   rdata_hold_a: assert property (avs_waitrequest_o && $past(avs_waitrequest_o) |-> $stable(avs_readdata_o))
      else $error("read data moved");
   cover property (avs_write_i && !avs_waitrequest_o);
   cover property (ra && avs_address_i == ADDR_STATUS);
   cover property (level_o == 8'hff);
endmodule : dcd_channel_properties
bind dcd_channel dcd_channel_properties u_prop (.clk_i(clk_i), .reset_n_i(reset_n_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .level_o(level_o));
`default_nettype wire

// >>> dcd_pkg.sv
`default_nettype none
package dcd_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_TIME_MS  = 10;
   localparam int TICK_CYCLES   = (TICK_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int HOUR_TIME_S   = 3600;
   localparam int HOUR_TICKS    = (HOUR_TIME_S * 1000) / TICK_TIME_MS;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam int         AW             = 5;
   localparam logic [4:0] ADDR_CTRL      = 5'h00;
   localparam logic [4:0] ADDR_LIMITS    = 5'h04;
   localparam logic [4:0] ADDR_TIMES     = 5'h08;
   localparam logic [4:0] ADDR_DYN_LEVEL = 5'h0c;
   localparam logic [4:0] ADDR_DYN_TIME  = 5'h10;
   localparam logic [4:0] ADDR_CMD       = 5'h14;
   localparam logic [4:0] ADDR_STATUS    = 5'h18;

   // byte field positions
   localparam int LIM_MIN_LSB  = 0;
   localparam int LIM_MAX_LSB  = 8;
   localparam int LIM_ON_LSB   = 16;
   localparam int TIM_SW_LSB   = 0;
   localparam int TIM_SET_LSB  = 8;
   localparam int TIM_REL_LSB  = 16;
   localparam int TIM_BURN_LSB = 24;
   localparam int DYL_INIT_LSB = 0;
   localparam int DYL_HOLD_LSB = 8;
   localparam int DYL_OFF_LSB  = 16;
   localparam int DYT_RISE_LSB = 0;
   localparam int DYT_HOLD_LSB = 8;
   localparam int DYT_FALL_LSB = 16;

   // reset values
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [31:0] LIMITS_RST    = 32'h00ff_ff01;
   localparam logic [31:0] TIMES_RST     = 32'h0128_140a;
   localparam logic [31:0] DYN_LEVEL_RST = 32'h0000_ffff;
   localparam logic [31:0] DYN_TIME_RST  = 32'h0032_640a;

   localparam logic [7:0] LVL_OFF  = 8'h00;
   localparam logic [7:0] LVL_FULL = 8'hff;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic [23:0] rsvd;
      logic        burn_en;
      logic        const_sw;
      logic        set_on;
      logic        perm_off;
      logic        perm_on;
      logic        central;
      logic        slave;
      logic        dyn;
   } dcd_ctrl_t;

   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_ON   = 3'h1,
      CMD_OFF  = 3'h2,
      CMD_SET  = 3'h3,
      CMD_UP   = 3'h4,
      CMD_DOWN = 3'h5,
      CMD_STOP = 3'h6
   } dcd_cmd_e;

   typedef struct packed {
      logic [14:0] rsvd_hi;
      logic        central;
      logic [7:0]  value;
      logic [4:0]  rsvd_lo;
      dcd_cmd_e    code;
   } dcd_cmd_t;

   typedef struct packed {
      logic       from_start;
      logic [7:0] start;
      logic [7:0] target;
      logic [7:0] den;
      logic       rate;
   } dcd_ramp_t;

   typedef enum logic [4:0] {
      DYN_IDLE = 5'h01,
      DYN_RISE = 5'h02,
      DYN_HOLD = 5'h04,
      DYN_FALL = 5'h08,
      DYN_OFF  = 5'h10
   } dcd_dyn_e;
endpackage : dcd_pkg
`default_nettype wire

// >>> dcd_ramp.sv
`timescale 1ns/100ps
`default_nettype none
module dcd_ramp (
   input  wire logic              clk_i,
   input  wire logic              reset_n_i,
   input  wire logic              tick_i,
   input  wire logic              load_i,
   input  wire dcd_pkg::dcd_ramp_t req_i,
   output logic [7:0]             level_o,
   output logic [7:0]             target_o,
   output logic                   busy_o
);
   import dcd_pkg::*;

   logic [7:0] num_q;
   logic [7:0] den_q;
   logic [9:0] acc_q;
   logic [7:0] base;

   function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
      abs_diff = (a > b) ? a - b : b - a;
   endfunction : abs_diff

   assign base = req_i.from_start ? req_i.start : level_o;

   // accumulator stepping: per tick add num, one level step per den
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         level_o  <= LVL_OFF;
         target_o <= LVL_OFF;
         num_q    <= 8'h00;
         den_q    <= 8'h00;
         acc_q    <= 10'h000;
         busy_o   <= 1'b0;
      end else if (load_i) begin
         level_o  <= (req_i.den == 8'h00) ? req_i.target : base;
         target_o <= req_i.target;
         den_q    <= req_i.den;
         num_q    <= req_i.rate ? LVL_FULL : abs_diff(req_i.target, base);
         acc_q    <= 10'h000;
         busy_o   <= (req_i.den != 8'h00) && (req_i.target != base);
      end else if (busy_o) begin
         if (level_o == target_o) begin
            busy_o <= 1'b0;
         end else if (acc_q >= {2'b00, den_q}) begin
            acc_q   <= acc_q - {2'b00, den_q};
            level_o <= (target_o > level_o) ? level_o + 8'h01 : level_o - 8'h01;
         end else if (tick_i) begin
            acc_q <= acc_q + {2'b00, num_q};
         end
      end
   end
endmodule : dcd_ramp
`default_nettype wire

// >>> dcd_tick.sv
`timescale 1ns/100ps
`default_nettype none
module dcd_tick #(
   parameter int TICK_CYCLES = dcd_pkg::TICK_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   output logic      tick_o
);
   import dcd_pkg::*;

   logic [31:0] cnt_q;

   // free running prescaler, one pulse per time unit
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cnt_q  <= 32'h0;
         tick_o <= 1'b0;
      end else if (cnt_q == 32'(TICK_CYCLES - 1)) begin
         cnt_q  <= 32'h0;
         tick_o <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 32'h1;
         tick_o <= 1'b0;
      end
   end
endmodule : dcd_tick
`default_nettype wire

// >>> tb_dcd_channel.sv
`timescale 1ns/100ps
`default_nettype none
module tb_dcd_channel;
   import dcd_pkg::*;
   logic        clk_i = 0, reset_n_i = 0, rd = 0, wr = 0, wq, dn, clr = 1;
   logic [4:0]  adr = 0;
   logic [31:0] wd = 0, q, rdat;
   logic [7:0]  lvl, mj, v;
   logic [31:0] rv [4] = '{LIMITS_RST, TIMES_RST, DYN_LEVEL_RST, DYN_TIME_RST};
   int          n_fail = 0, cmp_count = 0, cyc = 0;
   dcd_channel #(.TICK_CYCLES(300), .HOUR_TICKS(4)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .level_o(lvl));
   dcd_ballast_model u_lamp (.clk_i(clk_i), .clr_i(clr), .level_i(lvl), .down_o(dn), .jump_o(mj));
   initial forever #2 clk_i = ~clk_i;
   // cycle ceiling against hangs
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         report_and_stop();
      end
   end
   task report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   // one Avalon transfer, held until waitrequest low
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      rd <= ~w; wr <= w; adr <= a; wd <= d; n = 0;
      do begin @(posedge clk_i); n++; end while (wq !== 1'b0 && n < 50);
      if (n >= 50) begin n_fail++; report_and_stop(); end
      q = rdat;
      rd <= 1'b0; wr <= 1'b0;
   endtask : bus
   task cmd(input logic [2:0] c, input logic [7:0] val, input logic cen);
      bus(1'b1, ADDR_CMD, {15'h0, cen, val, 5'h0, c});
      repeat (3) @(posedge clk_i);
   endtask : cmd
   function automatic logic [7:0] clamp(input logic [7:0] x, mn, mx);
      if (mn > mx) mn = mx;
      return (x < mn) ? mn : (x > mx) ? mx : x;
   endfunction : clamp
   initial begin
      void'($urandom(32'h4fe6));
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      bus(0, ADDR_CTRL, 0); chk("ctrl", CTRL_RST, q);
      for (int i = 0; i < 4; i++) begin bus(0, 5'(4 * i + 4), 0); chk("regrst", rv[i], q); end
      bus(0, ADDR_STATUS, 0); chk("status", 32'h0001_0000, q);
      bus(0, ADDR_CMD, 0); chk("cmdread", 0, q);
      bus(1, 5'h1c, 32'hffff_ffff); bus(0, 5'h1c, 0); chk("unmapped", 0, q);
      bus(1, ADDR_TIMES, 32'h0228_0000); bus(1, ADDR_LIMITS, 32'h00f0_c020);
      cmd(CMD_ON, 0, 0); chk("on", 8'hc0, lvl);
      cmd(CMD_SET, 8'h50, 0); cmd(CMD_ON, 0, 0); chk("relit", 8'hc0, lvl);
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? 8'h01 : (i == 1) ? 8'hff : 8'($urandom_range(1, 255));
         cmd(CMD_SET, v, 0); chk("setclamp", clamp(v, 8'h20, 8'hc0), lvl);
      end
      cmd(CMD_SET, 8'hff, 1); chk("central", 8'hc0, lvl);
      bus(1, ADDR_LIMITS, 32'h00ff_4090);
      cmd(CMD_SET, 8'h10, 0); chk("minmax", 8'h40, lvl);
      bus(1, ADDR_LIMITS, 32'h00f0_c020); cmd(CMD_OFF, 0, 0); chk("off", 0, lvl);
      cmd(CMD_SET, 8'h60, 0); chk("setoff", 0, lvl);
      bus(1, ADDR_CTRL, 32'h20); cmd(CMD_SET, 8'h60, 0); chk("seton", 8'h60, lvl);
      bus(1, ADDR_CTRL, 32'ha0); repeat (3) @(posedge clk_i); chk("burn", 8'hff, lvl);
      bus(1, ADDR_CTRL, 32'h20); repeat (3) @(posedge clk_i); chk("burnend", 8'h60, lvl);
      cmd(CMD_SET, 8'h70, 0); cmd(CMD_ON, 0, 0);
      bus(1, ADDR_CTRL, 32'h22); repeat (3) @(posedge clk_i); chk("slaveon", 8'h70, lvl);
      cmd(CMD_ON, 0, 0); chk("slaveign", 8'h70, lvl);
      bus(1, ADDR_CTRL, 32'h26); cmd(CMD_ON, 0, 1); chk("ctrover", 8'hc0, lvl);
      bus(1, ADDR_CTRL, 32'h22); repeat (3) @(posedge clk_i); chk("ctrend", 8'h70, lvl);
      bus(1, ADDR_CTRL, 32'h20); repeat (3) @(posedge clk_i); chk("slaveoff", 8'h70, lvl);
      // relative dimming with a four tick full-scale time
      bus(1, ADDR_TIMES, 32'h0204_0000); cmd(CMD_OFF, 0, 0);
      cmd(CMD_UP, 0, 0); chk("upoff", 0, lvl);
      bus(1, ADDR_CTRL, 32'h28); cmd(CMD_UP, 0, 0); repeat (500) @(posedge clk_i);
      chk("dimrate", 1, lvl > 8'h20 && lvl < 8'hc0);
      repeat (1000) @(posedge clk_i); chk("dimup", 8'hc0, lvl);
      cmd(CMD_DOWN, 0, 0); repeat (1500) @(posedge clk_i); chk("dimdown", 8'h20, lvl);
      bus(1, ADDR_CTRL, 32'h38); cmd(CMD_DOWN, 0, 0); chk("dimoff", 0, lvl);
      cmd(CMD_UP, 0, 0); repeat (400) @(posedge clk_i); cmd(CMD_STOP, 0, 0); v = lvl;
      repeat (600) @(posedge clk_i); chk("stop", v, lvl);
      cmd(CMD_OFF, 0, 0); bus(1, ADDR_TIMES, 32'h0228_0002); clr <= 1'b0;
      cmd(CMD_ON, 0, 0); chk("ramping", 1, lvl != 8'hc0);
      repeat (900) @(posedge clk_i); chk("ramped", 8'hc0, lvl);
      chk("monotone", 0, dn); chk("step", 1, mj <= 8'h01);
      bus(1, ADDR_CTRL, 32'h01); bus(1, ADDR_DYN_LEVEL, 32'h0005_e010); bus(1, ADDR_DYN_TIME, 32'h0000_0200);
      cmd(CMD_ON, 0, 0); chk("dynhold", 8'he0, lvl);
      cmd(CMD_SET, 8'h40, 0); chk("dynset", 8'he0, lvl);
      cmd(CMD_OFF, 0, 0); chk("dynoff", 8'h05, lvl);
      cmd(CMD_ON, 0, 0); chk("dynretrig", 8'he0, lvl);
      bus(0, ADDR_STATUS, 0); chk("dynstate", 32'h0004_e0e0, q);
      repeat (700) @(posedge clk_i); chk("dynend", 8'h05, lvl);
      bus(0, ADDR_STATUS, 0); chk("dynlast", 32'h0010_0505, q);
      report_and_stop();
   end
endmodule : tb_dcd_channel
`default_nettype wire
